// ---- rtl/rms_status_regs.sv ----
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// - real filter output middle and low bytes readable in two registers.
// - quadrature output top three bits, middle and low bytes readable.
// - four pin levels shown; meaningful only with synchroniser enabled.
// - lock bit resets to one; updates only in rx/tx states, detect on.
// - lock bit zero means lock lost, one means in lock at the last update.
// - serial status bit 4 shows the slow RC oscillator clock.
// - serial status bit 3 is writable pin synchroniser enable.
// - serial status bit 2 shows the soft modulator clock.
// - serial status bits 1 and 0 show serial rx data and clock.
// - sync-found sets on sync event, clears on enter-receive strobe.
// - full flag sets when count exceeds threshold, clears when empty.
// - level flag high while count exceeds threshold.
// - empty flag high while queue holds no bytes.
// - overrun sets on byte arriving at full queue, clears on flush.
// - underrun sets on host read of empty queue, clears on flush.
// - preamble-reached sets on preamble, clears on sync found.
// - preamble lost clears flag after sync length plus ten symbols.
// - quality-valid resets to one, sets after 16/43 bits or preamble.
// - filter output valid only after sixteen filter samples.
`include "rms_defs.svh"

module rms_status_regs #(
  parameter logic [7:0] CHIP_ID  = `RMS_CHIP_ID_DEFAULT,
  parameter logic [7:0] CHIP_REV = `RMS_CHIP_REV_DEFAULT
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire rms_pkg::rms_wb_req_t      wb_req_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  input  wire rms_pkg::rms_filter_t      filter_i,
  input  wire logic [3:0]                gpio_pins_i,
  input  wire logic                      slow_rc_clock_i,
  input  wire rms_pkg::rms_serial_t      serial_i,
  input  wire rms_pkg::rms_radio_state_t radio_state_i,
  input  wire logic                      lock_detect_enable_i,
  input  wire logic                      synth_out_of_lock_i,
  input  wire rms_pkg::rms_rx_t          rx_i,
  output logic                           pin_synchronizer_enable_o,
  output logic [5:0]                     synth_test_bits_o
);
  import rms_pkg::*;

  rms_state_t s;
  rms_state_t next_s;

  function automatic logic lock_state_ok(input rms_radio_state_t st);
    return (st == RMS_ST_RX) || (st == RMS_ST_TX) ||
           (st == RMS_ST_SYNTH_TX);
  endfunction

  logic       level_now;
  logic       empty_now;
  logic       wr_strobe;
  logic [5:0] pre_limit;
  logic [5:0] pq_limit;
  logic [7:0] rd_byte;

  always_comb begin
    next_s    = s;
    empty_now = (rx_i.count == 8'h00);
    level_now = (rx_i.count > rx_i.threshold);
    pre_limit = 6'(rx_i.sync_len + `RMS_PRE_EXTRA_SYMS);
    pq_limit  = rx_i.preamble_valid_timeout_select ?
                `RMS_PQ_BITS_LONG : `RMS_PQ_BITS_SHORT;
    wr_strobe = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we &&
                !s.ack && wb_req_i.sel[0];

    // synchronisers for signals from other clocks and pins
    next_s.gpio_meta = gpio_pins_i;
    next_s.gpio_sync = s.gpio_meta;
    next_s.rc_meta   = slow_rc_clock_i;
    next_s.rc_sync   = s.rc_meta;

    // pin levels follow only while synchroniser is on
    if (s.pin_synchronizer_enable) begin
      next_s.gpio_state = s.gpio_sync;
    end

    // filter capture and startup count
    if (filter_i.sample_stb) begin
      next_s.real_val = filter_i.real_part[15:0];
      next_s.quad_val = filter_i.quad_part;
      if (s.samp_cnt != `RMS_FILT_SAMPLES) begin
        next_s.samp_cnt = 5'(s.samp_cnt + 5'h01);
      end
      if (s.samp_cnt == 5'(`RMS_FILT_SAMPLES - 5'h01)) begin
        next_s.filter_output_valid = 1'b1;
      end
    end

    // lock indicator
    if (lock_detect_enable_i && lock_state_ok(radio_state_i)) begin
      next_s.lock_bit = !synth_out_of_lock_i;
    end

    // sync found: set wins over clear
    if (rx_i.sync_event) begin
      next_s.sync_found = 1'b1;
    end else if (rx_i.enter_receive_strobe) begin
      next_s.sync_found = 1'b0;
    end

    // full flag
    if (level_now) begin
      next_s.full_flag = 1'b1;
    end else if (empty_now) begin
      next_s.full_flag = 1'b0;
    end

    // overrun and underrun, set wins over flush
    if (rx_i.byte_in && rx_i.at_capacity) begin
      next_s.overrun = 1'b1;
    end else if (rx_i.flush) begin
      next_s.overrun = 1'b0;
    end
    if (rx_i.host_read && empty_now) begin
      next_s.underrun = 1'b1;
    end else if (rx_i.flush) begin
      next_s.underrun = 1'b0;
    end

    // preamble reached with loss timeout
    if (rx_i.sync_event) begin
      next_s.pre_reached = 1'b0;
      next_s.pre_timer   = 6'h00;
    end else if (rx_i.preamble_seen) begin
      next_s.pre_reached = 1'b1;
      next_s.pre_timer   = 6'h00;
    end else if (s.pre_reached && rx_i.symbol_tick) begin
      if (6'(s.pre_timer + 6'h01) >= pre_limit) begin
        next_s.pre_reached = 1'b0;
        next_s.pre_timer   = 6'h00;
      end else begin
        next_s.pre_timer = 6'(s.pre_timer + 6'h01);
      end
    end

    // preamble quality valid, restarted by enter-receive strobe
    if (rx_i.enter_receive_strobe) begin
      next_s.pq_valid = 1'b0;
      next_s.bit_cnt  = 6'h00;
    end else begin
      if (rx_i.bit_tick && !s.pq_valid && s.bit_cnt != pq_limit) begin
        next_s.bit_cnt = 6'(s.bit_cnt + 6'h01);
      end
      if (rx_i.bit_tick && 6'(s.bit_cnt + 6'h01) >= pq_limit) begin
        next_s.pq_valid = 1'b1;
      end
    end
    // a detected preamble wins over the restart
    if (rx_i.preamble_seen) begin
      next_s.pq_valid = 1'b1;
    end

    // only writable fields respond to writes
    if (wr_strobe) begin
      unique case (wb_req_i.adr)
        `RMS_ADR_SERIAL: begin
          next_s.pin_synchronizer_enable =
            wb_req_i.dat[`RMS_SER_SYNC_EN];
        end
        `RMS_ADR_SYNTH_LOCK: begin
          next_s.test_bits = wb_req_i.dat[6:1];
        end
        default: begin
        end
      endcase
    end

    // read mux
    rd_byte = 8'h00;
    unique case (wb_req_i.adr)
      `RMS_ADR_REAL_MID:   rd_byte = s.real_val[15:8];
      `RMS_ADR_REAL_LOW:   rd_byte = s.real_val[7:0];
      `RMS_ADR_QUAD_HIGH:  rd_byte = {5'h00, s.quad_val[18:16]};
      `RMS_ADR_QUAD_MID:   rd_byte = s.quad_val[15:8];
      `RMS_ADR_QUAD_LOW:   rd_byte = s.quad_val[7:0];
      `RMS_ADR_PIN_LEVEL:  rd_byte = {4'h0, s.gpio_state};
      `RMS_ADR_SYNTH_LOCK: rd_byte = {1'b0, s.test_bits, s.lock_bit};
      `RMS_ADR_PHASE_TRIM: rd_byte = 8'h00;
      `RMS_ADR_CHIP_ID:    rd_byte = CHIP_ID;
      `RMS_ADR_CHIP_REV:   rd_byte = CHIP_REV;
      `RMS_ADR_SERIAL: begin
        rd_byte[`RMS_SER_RC_CLK]   = s.rc_sync;
        rd_byte[`RMS_SER_SYNC_EN]  = s.pin_synchronizer_enable;
        rd_byte[`RMS_SER_SOFT_CLK] = serial_i.soft_modulator_clock;
        rd_byte[`RMS_SER_RX_DATA]  = serial_i.ser_rx_data;
        rd_byte[`RMS_SER_RX_CLK]   = serial_i.ser_rx_clk;
      end
      `RMS_ADR_MODEM: begin
        rd_byte[`RMS_MOD_SYNC_FOUND]  = s.sync_found;
        rd_byte[`RMS_MOD_FULL]        = s.full_flag;
        rd_byte[`RMS_MOD_LEVEL]       = level_now;
        rd_byte[`RMS_MOD_EMPTY]       = empty_now;
        rd_byte[`RMS_MOD_OVERRUN]     = s.overrun;
        rd_byte[`RMS_MOD_UNDERRUN]    = s.underrun;
        rd_byte[`RMS_MOD_PRE_REACHED] = s.pre_reached;
        rd_byte[`RMS_MOD_PQ_VALID]    = s.pq_valid;
      end
      `RMS_ADR_FILT_STAT:
        rd_byte[`RMS_FILT_VALID] = s.filter_output_valid;
      default:             rd_byte = 8'h00;
    endcase

    // single-cycle ack, dropped the cycle after
    next_s.ack = wb_req_i.cyc && wb_req_i.stb && !s.ack;
    next_s.dat = next_s.ack ? {24'h000000, rd_byte} : 32'h00000000;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s           <= '0;
      s.lock_bit  <= `RMS_RST_LOCK;
      s.pq_valid  <= `RMS_RST_PQ_VALID;
      s.test_bits <= `RMS_RST_TEST_BITS;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o                  = s.dat;
  assign wb_ack_o                  = s.ack;
  assign pin_synchronizer_enable_o = s.pin_synchronizer_enable;
  assign synth_test_bits_o         = s.test_bits;

endmodule

// ---- rtl/rms_defs.svh ----
`ifndef RMS_DEFS_SVH
`define RMS_DEFS_SVH

// register byte addresses
`define RMS_ADR_REAL_MID     8'h00
`define RMS_ADR_REAL_LOW     8'h04
`define RMS_ADR_QUAD_HIGH    8'h08
`define RMS_ADR_QUAD_MID     8'h0c
`define RMS_ADR_QUAD_LOW     8'h10
`define RMS_ADR_PIN_LEVEL    8'h14
`define RMS_ADR_SYNTH_LOCK   8'h18
`define RMS_ADR_PHASE_TRIM   8'h1c
`define RMS_ADR_CHIP_ID      8'h20
`define RMS_ADR_CHIP_REV     8'h24
`define RMS_ADR_SERIAL       8'h28
`define RMS_ADR_MODEM        8'h2c
`define RMS_ADR_FILT_STAT    8'h30

// serial_observe_status fields
`define RMS_SER_RC_CLK       4
`define RMS_SER_SYNC_EN      3
`define RMS_SER_SOFT_CLK     2
`define RMS_SER_RX_DATA      1
`define RMS_SER_RX_CLK       0

// rx_modem_flags fields
`define RMS_MOD_SYNC_FOUND   7
`define RMS_MOD_FULL         6
`define RMS_MOD_LEVEL        5
`define RMS_MOD_EMPTY        4
`define RMS_MOD_OVERRUN      3
`define RMS_MOD_UNDERRUN     2
`define RMS_MOD_PRE_REACHED  1
`define RMS_MOD_PQ_VALID     0

// filter status field
`define RMS_FILT_VALID       3

// reset values
`define RMS_RST_LOCK         1'b1
`define RMS_RST_PQ_VALID     1'b1
`define RMS_RST_TEST_BITS    6'h00

// counts
`define RMS_FILT_SAMPLES     5'h10
`define RMS_PQ_BITS_SHORT    6'h10
`define RMS_PQ_BITS_LONG     6'h2b
`define RMS_PRE_EXTRA_SYMS   6'h0a

// identity, arbitrary neutral values
`define RMS_CHIP_ID_DEFAULT  8'h3c
`define RMS_CHIP_REV_DEFAULT 8'h01

`endif

// ---- rtl/rms_pkg.sv ----
package rms_pkg;

  typedef enum logic [2:0] {
    RMS_ST_IDLE,
    RMS_ST_RX,
    RMS_ST_TX,
    RMS_ST_SYNTH_TX,
    RMS_ST_OTHER
  } rms_radio_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rms_wb_req_t;

  typedef struct packed {
    logic        sample_stb;
    logic [18:0] real_part;
    logic [18:0] quad_part;
  } rms_filter_t;

  typedef struct packed {
    logic       sync_event;
    logic       enter_receive_strobe;
    logic       flush;
    logic       host_read;
    logic       byte_in;
    logic       at_capacity;
    logic [7:0] count;
    logic [7:0] threshold;
    logic       preamble_seen;
    logic       symbol_tick;
    logic       bit_tick;
    logic       preamble_valid_timeout_select;
    logic [5:0] sync_len;
  } rms_rx_t;

  typedef struct packed {
    logic soft_modulator_clock;
    logic ser_rx_data;
    logic ser_rx_clk;
  } rms_serial_t;

  typedef struct packed {
    logic             ack;
    logic [31:0]      dat;
    logic [15:0]      real_val;
    logic [18:0]      quad_val;
    logic [4:0]       samp_cnt;
    logic             filter_output_valid;
    logic             pin_synchronizer_enable;
    logic [5:0]       test_bits;
    logic             lock_bit;
    logic [3:0]       gpio_meta;
    logic [3:0]       gpio_sync;
    logic [3:0]       gpio_state;
    logic             rc_meta;
    logic             rc_sync;
    logic             sync_found;
    logic             full_flag;
    logic             overrun;
    logic             underrun;
    logic             pre_reached;
    logic [5:0]       pre_timer;
    logic             pq_valid;
    logic [5:0]       bit_cnt;
  } rms_state_t;

endpackage

// ---- tb/rms_status_regs_chk.sv ----
`timescale 1ns/1ns
module rms_status_regs_chk (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire rms_pkg::rms_wb_req_t      wb_req_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire rms_pkg::rms_filter_t      filter_i,
  input wire rms_pkg::rms_serial_t      serial_i,
  input wire rms_pkg::rms_radio_state_t radio_state_i,
  input wire logic                      lock_detect_enable_i,
  input wire logic                      synth_out_of_lock_i,
  input wire rms_pkg::rms_rx_t          rx_i,
  input wire logic                      pin_synchronizer_enable_o
);
  import rms_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tk;
  logic rd;
  assign tk = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign rd = tk & ~wb_req_i.we;
  property p_ack; tk |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data outside ack");
  property p_en; tk && wb_req_i.we && wb_req_i.sel[0] &&
    wb_req_i.adr == 8'h28 |=> pin_synchronizer_enable_o ==
    $past(wb_req_i.dat[3]); endproperty
  a_en: assert property (p_en) else $error("enable not written");
  property p_ro; tk && wb_req_i.we && wb_req_i.adr != 8'h28 |=>
    $stable(pin_synchronizer_enable_o); endproperty
  a_ro: assert property (p_ro) else $error("enable changed");
  property p_emp; rd && wb_req_i.adr == 8'h2c |=>
    wb_dat_o[4] == ($past(rx_i.count) == 8'h0); endproperty
  a_emp: assert property (p_emp) else $error("empty flag");
  property p_lvl; rd && wb_req_i.adr == 8'h2c |=>
    wb_dat_o[5] == ($past(rx_i.count) > $past(rx_i.threshold)); endproperty
  a_lvl: assert property (p_lvl) else $error("level flag");
  property p_syn; rx_i.sync_event ##1 (rd && wb_req_i.adr == 8'h2c) |=>
    wb_dat_o[7]; endproperty
  a_syn: assert property (p_syn) else $error("sync flag");
  property p_lck; lock_detect_enable_i && radio_state_i == RMS_ST_RX &&
    synth_out_of_lock_i ##1 (rd && wb_req_i.adr == 8'h18) |=>
    !wb_dat_o[0]; endproperty
  a_lck: assert property (p_lck) else $error("lock bit");
  property p_ser; rd && wb_req_i.adr == 8'h28 |=>
    wb_dat_o[2:0] == $past(serial_i); endproperty
  a_ser: assert property (p_ser) else $error("serial bits");
  property p_flt; filter_i.sample_stb ##1 (rd && wb_req_i.adr == 8'h00)
    |=> wb_dat_o[7:0] == $past(filter_i.real_part[15:8], 2); endproperty
  a_flt: assert property (p_flt) else $error("real mid byte");
  c_wr: cover property (tk && wb_req_i.we);
  c_syn: cover property (rx_i.sync_event);
  c_ovr: cover property (wb_ack_o && wb_dat_o[3]);
endmodule

// ---- tb/rms_status_regs_test.sv ----
`timescale 1ns/1ns
module rms_status_regs_test;
  import rms_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  rms_wb_req_t      q = '0;
  rms_filter_t      f = '0;
  rms_serial_t      s = '0;
  rms_rx_t          x = '0;
  rms_radio_state_t st = RMS_ST_IDLE;
  logic [3:0]       pins = 4'h0;
  logic             rc = 1'b0;
  logic             len = 1'b0;
  logic             ool = 1'b0;
  logic             pse;
  logic [31:0]      dat;
  logic             ack;
  logic [5:0]       tb6;
  int               fails = 0;
  int               n_compared = 0;
  always #4 clk_i = ~clk_i;
  rms_status_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(q),
    .wb_dat_o(dat), .wb_ack_o(ack), .filter_i(f), .gpio_pins_i(pins),
    .slow_rc_clock_i(rc), .serial_i(s), .radio_state_i(st),
    .lock_detect_enable_i(len), .synth_out_of_lock_i(ool), .rx_i(x),
    .pin_synchronizer_enable_o(pse), .synth_test_bits_o(tb6));
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    q <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      wrap_up();
    end
    r = dat[7:0];
    q.cyc <= 1'b0;
    q.stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    cmp(r & m, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask
  // one-cycle pulse: 0 sync 1 enter rx 2 flush 3 byte 4 read 5 sym 6 bit
  task automatic pls(input int k);
    for (int on = 1; on >= 0; on--) begin
      x.sync_event <= on == 1 && k == 0;
      x.enter_receive_strobe <= on == 1 && k == 1;
      x.flush <= on == 1 && k == 2;
      x.byte_in <= on == 1 && k == 3;
      x.host_read <= on == 1 && k == 4;
      x.symbol_tick <= on == 1 && k == 5;
      x.bit_tick <= on == 1 && k == 6;
      @(posedge clk_i);
    end
  endtask
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    ck(8'h18, 8'h01, 8'h01);
    ck(8'h2c, 8'hff, 8'h11);
    for (int a = 0; a <= 16; a += 4) ck(a[7:0], 8'hff, 8'h00);
    ck(8'h40, 8'hff, 8'h00);
    wr(8'h2c, 8'hff);
    ck(8'h2c, 8'hff, 8'h11);
    wr(8'h28, 8'h08);
    ck(8'h28, 8'h08, 8'h08);
    cmp({7'h00, pse}, 8'h01);
    pins <= 4'ha;
    rc <= 1'b1;
    s <= 3'b101;
    repeat (5) @(posedge clk_i);
    ck(8'h14, 8'hff, 8'h0a);
    ck(8'h28, 8'h17, 8'h15);
    wr(8'h18, 8'h7e);
    ck(8'h18, 8'h7e, 8'h7e);
    cmp({2'b00, tb6}, 8'h3f);
    st <= RMS_ST_RX;
    len <= 1'b1;
    ool <= 1'b1;
    @(posedge clk_i);
    ck(8'h18, 8'h01, 8'h00);
    ool <= 1'b0;
    @(posedge clk_i);
    ck(8'h18, 8'h01, 8'h01);
    st <= RMS_ST_IDLE;
    ool <= 1'b1;
    @(posedge clk_i);
    ck(8'h18, 8'h01, 8'h01);
    f <= '{1'b1, 19'h4b2d1, 19'h6e5f7};
    repeat (15) @(posedge clk_i);
    f.sample_stb <= 1'b0;
    @(posedge clk_i);
    ck(8'h30, 8'h08, 8'h00);
    f.sample_stb <= 1'b1;
    @(posedge clk_i);
    f.sample_stb <= 1'b0;
    ck(8'h00, 8'hff, 8'hb2);
    ck(8'h30, 8'h08, 8'h08);
    ck(8'h04, 8'hff, 8'hd1);
    ck(8'h08, 8'hff, 8'h06);
    ck(8'h0c, 8'hff, 8'he5);
    ck(8'h10, 8'hff, 8'hf7);
    pls(0);
    ck(8'h2c, 8'h80, 8'h80);
    pls(1);
    ck(8'h2c, 8'h81, 8'h00);
    repeat (15) pls(6);
    ck(8'h2c, 8'h01, 8'h00);
    pls(6);
    ck(8'h2c, 8'h01, 8'h01);
    x.preamble_valid_timeout_select <= 1'b1;
    pls(1);
    repeat (42) pls(6);
    ck(8'h2c, 8'h01, 8'h00);
    pls(6);
    ck(8'h2c, 8'h01, 8'h01);
    x.count <= 8'h09;
    x.threshold <= 8'h08;
    @(posedge clk_i);
    ck(8'h2c, 8'h70, 8'h60);
    x.count <= 8'h08;
    @(posedge clk_i);
    ck(8'h2c, 8'h70, 8'h40);
    x.count <= 8'h00;
    @(posedge clk_i);
    ck(8'h2c, 8'h70, 8'h10);
    x.at_capacity <= 1'b1;
    pls(3);
    ck(8'h2c, 8'h0c, 8'h08);
    pls(4);
    ck(8'h2c, 8'h0c, 8'h0c);
    pls(2);
    ck(8'h2c, 8'h0c, 8'h00);
    x.sync_len <= 6'h02;
    x.preamble_seen <= 1'b1;
    @(posedge clk_i);
    ck(8'h2c, 8'h02, 8'h02);
    x.preamble_seen <= 1'b0;
    repeat (11) pls(5);
    ck(8'h2c, 8'h02, 8'h02);
    pls(5);
    ck(8'h2c, 8'h02, 8'h00);
    x.preamble_seen <= 1'b1;
    pls(1);
    ck(8'h2c, 8'h03, 8'h03);
    x.preamble_seen <= 1'b0;
    pls(0);
    ck(8'h2c, 8'h03, 8'h01);
    wrap_up();
  end
endmodule
bind rms_status_regs rms_status_regs_chk u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .filter_i(filter_i), .serial_i(serial_i),
  .radio_state_i(radio_state_i),
  .lock_detect_enable_i(lock_detect_enable_i),
  .synth_out_of_lock_i(synth_out_of_lock_i), .rx_i(rx_i),
  .pin_synchronizer_enable_o(pin_synchronizer_enable_o));
